// *** inc/count_pkg.sv ***
/*
 counting channel constants, mode encodings and the rule summary.
 assumes one 10 MHz module clock shared by every file that imports it.
*/
// What this block does
// - hysteresis band stops comparison output chatter
// - serial mode has no gating or loading
// - serial frames may be gray or binary
// - serial mode captures position on aux edges
// - capture every edge or once per enable
// - frame length configurable from 10 to 40
// - position field between lsb and msb, max 32
// - fields up to 31 bits are unsigned
// - 32-bit field is signed two's complement
// - raw frame returns low 32 bits, zero-padded
// - crossing is further pulse beyond a limit
// - crossings set high and low limit flags
// - limit flags held until clear bit asserted
// - after crossing stop or continue, reload chosen
// - auto gate stop needs gate close and reopen
// - program gate request mirrored as status bit
// - optional hardware gate from filtered aux inputs
// - level mode gate follows active input level
// - edge mode opens and closes on edges
// - effective gate is program and hardware gate
// - pulses ignored while effective gate closed
// - gate opening loads start or continues
// - limits are signed 32-bit values
package count_pkg;
    localparam int FRAME_MAX = 40;
    localparam int FRAME_MIN = 10;
    localparam int POS_W = 32;
    localparam int BIT_IDX_W = 6;
    localparam int NUM_AUX = 2;
    localparam int AUX_SEL_W = 1;
    localparam int FILT_W = 8;
    localparam logic [POS_W-1:0] ZERO_WORD = 32'h00000000;
    localparam logic [BIT_IDX_W-1:0] SIGNED_FIELD_W = 6'h20;
    localparam logic [FILT_W-1:0] FILT_ZERO = 8'h00;
    localparam logic [FILT_W-1:0] FILT_ONE = 8'h01;

    typedef enum logic [1:0] {
        HW_NONE,
        HW_LEVEL,
        HW_EDGES
    } hw_gate_mode_e;

    typedef enum logic [1:0] {
        EDGE_RISE,
        EDGE_FALL,
        EDGE_BOTH
    } edge_sel_e;
endpackage

// *** hw/aux_filter.sv ***
/*
 one aux input: two-flop synchroniser then a stability filter.
 assumes the pin is asynchronous to clock; delay is in clock cycles.
*/
`timescale 1ns/1ps
module aux_filter
    import count_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic pin,
    input wire logic [FILT_W-1:0] filter_cycles,
    output logic level
);
    logic sync1_ff;
    logic sync2_ff;
    logic [FILT_W-1:0] stable_ff;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end else begin
            sync1_ff <= pin;
            sync2_ff <= sync1_ff;
        end
    end

    // the level only moves after the new value has held for the delay
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            stable_ff <= FILT_ZERO;
            level <= 1'b0;
        end else if (sync2_ff == level) begin
            stable_ff <= FILT_ZERO;
        end else if (stable_ff >= filter_cycles) begin
            level <= sync2_ff;
            stable_ff <= FILT_ZERO;
        end else begin
            stable_ff <= stable_ff + FILT_ONE;
        end
    end
endmodule

// *** hw/count_channel.sv ***
/*
 counting channel: gate resolution, limit handling, serial position
 extraction, capture and comparison output with hysteresis.
 assumes count pulses and frame_valid are one-cycle strobes on clock,
 and that the serial receiver delivers whole frames right-aligned.
*/
`timescale 1ns/1ps
module count_channel
    import count_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic serial_mode,
    input wire logic up_pulse,
    input wire logic down_pulse,
    input wire logic [NUM_AUX-1:0] aux_input_m,
    input wire logic [FILT_W-1:0] filter_cycles,
    input wire logic program_gate_request,
    input wire hw_gate_mode_e hw_gate_mode,
    input wire logic level_active_high,
    input wire logic [AUX_SEL_W-1:0] open_input_sel,
    input wire logic [AUX_SEL_W-1:0] close_input_sel,
    input wire edge_sel_e open_edge,
    input wire edge_sel_e close_edge,
    input wire logic signed [POS_W-1:0] high_limit,
    input wire logic signed [POS_W-1:0] low_limit,
    input wire logic signed [POS_W-1:0] start_value,
    input wire logic auto_gate_stop,
    input wire logic reload_opposite,
    input wire logic load_on_gate_open,
    input wire logic clear_limit_flags,
    input wire logic [FRAME_MAX-1:0] frame_data,
    input wire logic frame_valid,
    input wire logic [BIT_IDX_W-1:0] frame_length,
    input wire logic [BIT_IDX_W-1:0] field_lsb,
    input wire logic [BIT_IDX_W-1:0] field_msb,
    input wire logic gray_coded,
    input wire logic raw_frame_select,
    input wire logic capture_enable,
    input wire logic [AUX_SEL_W-1:0] capture_input_sel,
    input wire edge_sel_e capture_edge,
    input wire logic capture_periodic,
    input wire logic signed [POS_W-1:0] compare_value,
    input wire logic [POS_W-1:0] hysteresis,
    output logic signed [POS_W-1:0] count_value,
    output logic [POS_W-1:0] position_value,
    output logic [POS_W-1:0] capture_value,
    output logic capture_event,
    output logic high_limit_crossed_flag,
    output logic low_limit_crossed_flag,
    output logic program_gate_state,
    output logic effective_gate_state,
    output logic [NUM_AUX-1:0] aux_input_level_flag,
    output logic compare_output
);
    logic [NUM_AUX-1:0] aux_prev_ff;
    logic [NUM_AUX-1:0] aux_rise;
    logic [NUM_AUX-1:0] aux_fall;
    logic hw_edge_gate_ff;
    logic hw_gate_open;
    logic stopped_ff;
    logic eff_prev_ff;
    logic gate_open;
    logic hi_cross;
    logic lo_cross;
    logic capture_armed_ff;
    logic [FRAME_MAX-1:0] bin_frame;
    logic [FRAME_MAX-1:0] shifted;
    logic [BIT_IDX_W-1:0] field_w;
    logic [POS_W-1:0] field_val;
    logic [POS_W-1:0] nxt_position;
    logic signed [POS_W-1:0] pos_signed;
    logic signed [POS_W-1:0] cmp_src;
    logic signed [POS_W+1:0] band_hi;
    logic signed [POS_W+1:0] band_lo;
    logic signed [POS_W+1:0] cmp_wide;
    logic signed [POS_W-1:0] nxt_count;

    // edge detection on filtered levels
    function automatic logic edge_hit(input edge_sel_e sel, input logic r,
                                      input logic f);
        case (sel)
            EDGE_RISE: edge_hit = r;
            EDGE_FALL: edge_hit = f;
            EDGE_BOTH: edge_hit = r | f;
            default: edge_hit = 1'b0;
        endcase
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < NUM_AUX; gi++) begin : g_aux
            aux_filter u_filt (
                .clock(clock),
                .reset_n(reset_n),
                .pin(aux_input_m[gi]),
                .filter_cycles(filter_cycles),
                .level(aux_input_level_flag[gi])
            );
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            aux_prev_ff <= '0;
        end else begin
            aux_prev_ff <= aux_input_level_flag;
        end
    end
    assign aux_rise = aux_input_level_flag & ~aux_prev_ff;
    assign aux_fall = ~aux_input_level_flag & aux_prev_ff;

    // opening edge wins if both land in one cycle
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            hw_edge_gate_ff <= 1'b0;
        end else if (edge_hit(open_edge, aux_rise[open_input_sel],
                              aux_fall[open_input_sel])) begin
            hw_edge_gate_ff <= 1'b1;
        end else if (edge_hit(close_edge, aux_rise[close_input_sel],
                              aux_fall[close_input_sel])) begin
            hw_edge_gate_ff <= 1'b0;
        end
    end

    always_comb begin
        case (hw_gate_mode)
            HW_NONE: hw_gate_open = 1'b1;
            HW_LEVEL: hw_gate_open =
                aux_input_level_flag[open_input_sel] == level_active_high;
            HW_EDGES: hw_gate_open = hw_edge_gate_ff;
            default: hw_gate_open = 1'b1;
        endcase
    end

    assign program_gate_state = program_gate_request;
    // serial mode has no gate at all
    assign gate_open = !serial_mode && program_gate_request &&
                       hw_gate_open;
    assign effective_gate_state = gate_open && !stopped_ff;

    // the stop latch only releases once the combined gate closes
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            stopped_ff <= 1'b0;
        end else if (!gate_open) begin
            stopped_ff <= 1'b0;
        end else if (auto_gate_stop && (hi_cross || lo_cross)) begin
            stopped_ff <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            eff_prev_ff <= 1'b0;
        end else begin
            eff_prev_ff <= effective_gate_state;
        end
    end

    assign hi_cross = effective_gate_state && up_pulse && !down_pulse &&
                      count_value == high_limit;
    assign lo_cross = effective_gate_state && down_pulse && !up_pulse &&
                      count_value == low_limit;

    always_comb begin
        nxt_count = count_value;
        if (effective_gate_state && !eff_prev_ff && load_on_gate_open) begin
            nxt_count = start_value;
        end else if (hi_cross) begin
            nxt_count = reload_opposite ? low_limit : start_value;
        end else if (lo_cross) begin
            nxt_count = reload_opposite ? high_limit : start_value;
        end else if (effective_gate_state && up_pulse && !down_pulse) begin
            nxt_count = count_value + 32'sh00000001;
        end else if (effective_gate_state && down_pulse && !up_pulse) begin
            nxt_count = count_value - 32'sh00000001;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            count_value <= ZERO_WORD;
        end else begin
            count_value <= nxt_count;
        end
    end

    // a crossing in the clear cycle keeps its flag set
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            high_limit_crossed_flag <= 1'b0;
            low_limit_crossed_flag <= 1'b0;
        end else begin
            high_limit_crossed_flag <= hi_cross ||
                (high_limit_crossed_flag && !clear_limit_flags);
            low_limit_crossed_flag <= lo_cross ||
                (low_limit_crossed_flag && !clear_limit_flags);
        end
    end

    // gray to binary: each bit is the xor of its own gray bit and all gray bits above it
    always_comb begin
        bin_frame = frame_data;
        if (gray_coded) begin
            for (int i = FRAME_MAX - 2; i >= 0; i--) begin
                bin_frame[i] = bin_frame[i+1] ^ frame_data[i];
            end
        end
    end

    // the receiver right-aligns frames, so unused high bits are zero
    always_comb begin
        shifted = bin_frame >> field_lsb;
        field_w = field_msb - field_lsb + 6'h01;
        field_val = shifted[POS_W-1:0];
        for (int i = 0; i < POS_W; i++) begin
            if (i >= field_w) begin
                field_val[i] = 1'b0;
            end
        end
        if (raw_frame_select) begin
            nxt_position = frame_data[POS_W-1:0];
        end else begin
            nxt_position = field_val;
        end
    end

    // lengths outside the supported span leave the last position
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            position_value <= ZERO_WORD;
        end else if (frame_valid && frame_length >= BIT_IDX_W'(FRAME_MIN) &&
                     frame_length <= BIT_IDX_W'(FRAME_MAX)) begin
            position_value <= nxt_position;
        end
    end

    assign pos_signed = position_value;

    // enable drop clears the event and rearms the one-shot
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            capture_value <= ZERO_WORD;
            capture_event <= 1'b0;
            capture_armed_ff <= 1'b0;
        end else if (!capture_enable) begin
            capture_event <= 1'b0;
            capture_armed_ff <= 1'b1;
        end else if (serial_mode && (capture_armed_ff || capture_periodic) &&
                     edge_hit(capture_edge, aux_rise[capture_input_sel],
                              aux_fall[capture_input_sel])) begin
            capture_value <= position_value;
            capture_event <= 1'b1;
            capture_armed_ff <= 1'b0;
        end
    end

    // 32-bit fields compare signed; narrower ones are positive anyway
    assign cmp_src = serial_mode ? pos_signed : count_value;
    assign cmp_wide = {{2{cmp_src[POS_W-1]}}, cmp_src};
    assign band_hi = {{2{compare_value[POS_W-1]}}, compare_value} +
                     $signed({2'b00, hysteresis});
    assign band_lo = {{2{compare_value[POS_W-1]}}, compare_value} -
                     $signed({2'b00, hysteresis});

    // output only switches once the value leaves the band
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            compare_output <= 1'b0;
        end else if (cmp_wide > band_hi) begin
            compare_output <= 1'b1;
        end else if (cmp_wide < band_lo) begin
            compare_output <= 1'b0;
        end
    end

    property p_cross_sets_high;
        @(posedge clock) disable iff (!reset_n)
        hi_cross |=> high_limit_crossed_flag;
    endproperty
    a_cross_sets_high: assert property (p_cross_sets_high)
        else $error("high crossing did not set flag");

    property p_flag_hold;
        @(posedge clock) disable iff (!reset_n)
        high_limit_crossed_flag && !clear_limit_flags |=>
            high_limit_crossed_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("high flag dropped without clear");

    property p_flag_clear;
        @(posedge clock) disable iff (!reset_n)
        clear_limit_flags && !lo_cross |=> !low_limit_crossed_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("low flag not cleared");

    property p_gate_closed_hold;
        @(posedge clock) disable iff (!reset_n)
        !effective_gate_state ##1 !effective_gate_state |->
            $stable(count_value);
    endproperty
    a_gate_closed_hold: assert property (p_gate_closed_hold)
        else $error("count moved while gate closed");

    property p_gate_and;
        @(posedge clock) disable iff (!reset_n)
        effective_gate_state |-> program_gate_request && hw_gate_open;
    endproperty
    a_gate_and: assert property (p_gate_and)
        else $error("gate open without both gates");

    sequence s_stop_cross;
        auto_gate_stop && hi_cross && gate_open;
    endsequence
    property p_auto_stop;
        @(posedge clock) disable iff (!reset_n)
        s_stop_cross ##1 gate_open |-> !effective_gate_state;
    endproperty
    a_auto_stop: assert property (p_auto_stop)
        else $error("gate stayed open after auto stop");

    property p_high_reload;
        @(posedge clock) disable iff (!reset_n)
        hi_cross && !(effective_gate_state && !eff_prev_ff &&
                      load_on_gate_open) |=>
            count_value == ($past(reload_opposite) ? $past(low_limit) :
                            $past(start_value));
    endproperty
    a_high_reload: assert property (p_high_reload)
        else $error("wrong reload after high crossing");

    property p_serial_nogate;
        @(posedge clock) disable iff (!reset_n)
        serial_mode |-> !effective_gate_state;
    endproperty
    a_serial_nogate: assert property (p_serial_nogate)
        else $error("gate open in serial mode");

    property p_gate_open_load;
        @(posedge clock) disable iff (!reset_n)
        effective_gate_state && !eff_prev_ff && load_on_gate_open |=>
            count_value == $past(start_value);
    endproperty
    a_gate_open_load: assert property (p_gate_open_load)
        else $error("start value not loaded on gate open");
endmodule

// *** testbench/encoder_model.sv ***
/*
 far-side encoder model: count strobes and serial position frames.
 assumes its tasks are called at the falling clock edge.
*/
`timescale 1ns/1ps
module encoder_model
    import count_pkg::*;
(
    input wire logic clock,
    output logic up_pulse,
    output logic down_pulse,
    output logic [FRAME_MAX-1:0] frame_data,
    output logic frame_valid
);
    initial begin
        up_pulse = 1'b0;
        down_pulse = 1'b0;
        frame_data = 40'h0000000000;
        frame_valid = 1'b0;
    end
    // strobes back to back, one per cycle
    task automatic pulses(input int n, input logic up);
        repeat (n) begin
            up_pulse = up;
            down_pulse = !up;
            @(negedge clock);
        end
        up_pulse = 1'b0;
        down_pulse = 1'b0;
    endtask
    // data is not held after the strobe, so show its inverse
    task automatic send_frame(input logic [FRAME_MAX-1:0] d);
        frame_data = d;
        frame_valid = 1'b1;
        @(negedge clock);
        frame_valid = 1'b0;
        frame_data = ~d;
    endtask
endmodule

// *** testbench/tb_top.sv ***
/*
 self-checking bench for count_channel with an encoder model.
 assumes inputs change at the falling edge, reset held 16 cycles.
*/
`timescale 1ns/1ps
module tb_top
    import count_pkg::*;
;
    logic clock, reset_n, serial_mode, up_pulse, down_pulse, frame_valid;
    logic program_gate_request, level_active_high, auto_gate_stop;
    logic reload_opposite, load_on_gate_open, clear_limit_flags;
    logic gray_coded, raw_frame_select, capture_enable, capture_periodic;
    logic [AUX_SEL_W-1:0] open_input_sel, close_input_sel, capture_input_sel;
    logic [NUM_AUX-1:0] aux_input_m, aux_input_level_flag;
    logic [FILT_W-1:0] filter_cycles;
    logic [BIT_IDX_W-1:0] frame_length, field_lsb, field_msb;
    logic [FRAME_MAX-1:0] frame_data;
    logic signed [POS_W-1:0] high_limit, low_limit, start_value;
    logic signed [POS_W-1:0] compare_value, count_value;
    logic [POS_W-1:0] hysteresis, position_value, capture_value;
    logic capture_event, high_limit_crossed_flag, low_limit_crossed_flag;
    logic program_gate_state, effective_gate_state, compare_output;
    hw_gate_mode_e hw_gate_mode;
    edge_sel_e open_edge, close_edge, capture_edge;
    int fails, checks_done;

    count_channel i_count_channel (
        .clock, .reset_n, .serial_mode, .up_pulse, .down_pulse,
        .aux_input_m, .filter_cycles, .program_gate_request,
        .hw_gate_mode, .level_active_high, .open_input_sel,
        .close_input_sel, .open_edge, .close_edge, .high_limit,
        .low_limit, .start_value, .auto_gate_stop, .reload_opposite,
        .load_on_gate_open, .clear_limit_flags, .frame_data, .frame_valid,
        .frame_length, .field_lsb, .field_msb, .gray_coded,
        .raw_frame_select, .capture_enable, .capture_input_sel,
        .capture_edge, .capture_periodic, .compare_value, .hysteresis,
        .count_value, .position_value, .capture_value, .capture_event,
        .high_limit_crossed_flag, .low_limit_crossed_flag,
        .program_gate_state, .effective_gate_state, .aux_input_level_flag,
        .compare_output
    );
    encoder_model i_encoder_model (
        .clock, .up_pulse, .down_pulse, .frame_data, .frame_valid
    );

    initial begin
        clock = 1'b0;
        forever #50 clock = !clock;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic chk(input logic [63:0] got, exp, input string w);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // the filtered level must follow the pin within a bounded time
    task automatic aux(input int i, input logic v);
        int k;
        k = 0;
        aux_input_m[i] = v;
        while (aux_input_level_flag[i] !== v && k < 50) begin
            tick(1);
            k++;
        end
        if (aux_input_level_flag[i] !== v) begin
            fails++;
            $display("[ERR] %0t aux level timeout", $time);
            final_report();
        end
        tick(3);
    endtask
    task automatic pls(input int n, input logic up);
        i_encoder_model.pulses(n, up);
        tick(2);
    endtask
    task automatic frm(input logic [39:0] d, input logic [31:0] e);
        i_encoder_model.send_frame(d);
        tick(2);
        chk(position_value, e, "position");
    endtask
    task automatic clr;
        clear_limit_flags = 1'b1;
        tick(1);
        clear_limit_flags = 1'b0;
        tick(1);
    endtask

    initial begin
        fails = 0;
        checks_done = 0;
        {reset_n, serial_mode, program_gate_request, auto_gate_stop,
         reload_opposite, clear_limit_flags, gray_coded, raw_frame_select,
         capture_enable, capture_periodic, open_input_sel,
         capture_input_sel, aux_input_m} = '0;
        level_active_high = 1'b1;
        load_on_gate_open = 1'b1;
        close_input_sel = 1'b1;
        filter_cycles = 8'h02;
        frame_length = 6'h14;
        field_lsb = 6'h04;
        field_msb = 6'h0B;
        high_limit = 32'h00000008;
        low_limit = 32'hFFFFFFFD;
        start_value = 32'h00000005;
        compare_value = 32'h00000014;
        hysteresis = 32'h00000003;
        hw_gate_mode = HW_NONE;
        open_edge = EDGE_RISE;
        close_edge = EDGE_RISE;
        capture_edge = EDGE_RISE;
        tick(16);
        reset_n = 1'b1;
        tick(1);
        chk({high_limit_crossed_flag, low_limit_crossed_flag}, 0, "rst");
        pls(2, 1'b1);
        chk(count_value, 32'h00000000, "shut gate");
        chk(effective_gate_state, 0, "gate shut");
        program_gate_request = 1'b1;
        tick(2);
        chk(program_gate_state, 1, "mirror");
        chk(count_value, 32'h00000005, "open load");
        pls(3, 1'b1);
        chk({count_value[3:0], high_limit_crossed_flag}, 5'h10, "at hi");
        pls(1, 1'b1);
        chk(count_value, 32'h00000005, "reload start");
        pls(1, 1'b1);
        chk(high_limit_crossed_flag, 1, "hi sticky");
        clr();
        chk(high_limit_crossed_flag, 0, "hi clear");
        reload_opposite = 1'b1;
        pls(9, 1'b0);
        chk({count_value, low_limit_crossed_flag}, 33'h1FFFFFFFA, "at lo");
        pls(1, 1'b0);
        chk(count_value, 32'h00000008, "reload opp");
        chk(low_limit_crossed_flag, 1, "lo flag");
        clr();
        auto_gate_stop = 1'b1;
        reload_opposite = 1'b0;
        load_on_gate_open = 1'b0;
        pls(1, 1'b1);
        chk(effective_gate_state, 0, "auto stop");
        pls(2, 1'b1);
        chk(count_value, 32'h00000005, "stopped");
        program_gate_request = 1'b0;
        tick(2);
        program_gate_request = 1'b1;
        tick(2);
        pls(1, 1'b1);
        chk(count_value, 32'h00000006, "resume");
        auto_gate_stop = 1'b0;
        clr();
        $display("limit and gate test done");
        hw_gate_mode = HW_LEVEL;
        tick(2);
        pls(2, 1'b1);
        chk(count_value, 32'h00000006, "lvl shut");
        aux(0, 1'b1);
        chk(effective_gate_state, 1, "lvl open");
        pls(2, 1'b1);
        chk(count_value, 32'h00000008, "lvl count");
        level_active_high = 1'b0;
        tick(1);
        chk(effective_gate_state, 0, "lvl low active");
        level_active_high = 1'b1;
        aux(0, 1'b0);
        hw_gate_mode = HW_EDGES;
        aux(1, 1'b1);
        aux(1, 1'b0);
        chk(effective_gate_state, 0, "edge idle shut");
        aux(0, 1'b1);
        aux(0, 1'b0);
        chk(effective_gate_state, 1, "edge open");
        aux(1, 1'b1);
        chk(effective_gate_state, 0, "edge shut");
        aux(1, 1'b0);
        $display("hardware gate test done");
        hw_gate_mode = HW_NONE;
        program_gate_request = 1'b0;
        serial_mode = 1'b1;
        frm(40'h0000000ABC, 32'h000000AB);
        gray_coded = 1'b1;
        frm(40'h0000000FE2, 32'h000000AB);
        gray_coded = 1'b0;
        frame_length = 6'h28;
        field_lsb = 6'h08;
        field_msb = 6'h27;
        frm(40'hFFFFFFFE00, 32'hFFFFFFFE);
        field_msb = 6'h26;
        frm(40'hFFFFFFFE00, 32'h7FFFFFFE);
        frame_length = 6'h09;
        frm(40'h0000000100, 32'h7FFFFFFE);
        frame_length = 6'h0A;
        field_lsb = 6'h00;
        field_msb = 6'h09;
        frm(40'h00000003FF, 32'h000003FF);
        raw_frame_select = 1'b1;
        frame_length = 6'h0C;
        frm(40'h0000000A5C, 32'h00000A5C);
        frame_length = 6'h28;
        frm(40'h123456789A, 32'h3456789A);
        raw_frame_select = 1'b0;
        pls(2, 1'b1);
        chk(count_value, 32'h00000008, "no count");
        frame_length = 6'h10;
        field_msb = 6'h0F;
        frm(40'h0000000010, 32'h00000010);
        chk(compare_output, 0, "below");
        frm(40'h0000000015, 32'h00000015);
        chk(compare_output, 0, "hold lo");
        frm(40'h0000000018, 32'h00000018);
        chk(compare_output, 1, "above");
        frm(40'h0000000013, 32'h00000013);
        chk(compare_output, 1, "hold hi");
        capture_enable = 1'b1;
        aux(0, 1'b1);
        chk({capture_event, capture_value}, 33'h100000013, "cap");
        frm(40'h0000000030, 32'h00000030);
        aux(0, 1'b0);
        aux(0, 1'b1);
        chk(capture_value, 32'h00000013, "cap once");
        capture_enable = 1'b0;
        tick(2);
        chk(capture_event, 0, "cap off");
        capture_periodic = 1'b1;
        capture_enable = 1'b1;
        aux(0, 1'b0);
        chk(capture_value, 32'h00000013, "no fall");
        aux(0, 1'b1);
        chk(capture_value, 32'h00000030, "periodic");
        capture_edge = EDGE_BOTH;
        frm(40'h0000000040, 32'h00000040);
        aux(0, 1'b0);
        chk(capture_value, 32'h00000040, "both");
        capture_edge = EDGE_FALL;
        frm(40'h0000000050, 32'h00000050);
        aux(0, 1'b1);
        chk(capture_value, 32'h00000040, "no rise");
        aux(0, 1'b0);
        chk(capture_value, 32'h00000050, "fall");
        $display("serial test done");
        final_report();
    end
endmodule
